//--- hw/tmcp_edge.sv
// Edge detector for the timer input pin.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
module tmcp_edge (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);
  logic prev_ff;
  logic nxt_prev;

  // Edges only resolve if the source toggles slowly enough
  assign rise = sig && !prev_ff;
  assign fall = !sig && prev_ff;

  always_comb begin
    nxt_prev = sig;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end
endmodule

//--- hw/tmcp_prescaler.sv
// Power-of-two prescaler giving a one-cycle tick.
// Assumes the enable drops whenever the timer is disabled.
`timescale 1ns/1ps
module tmcp_prescaler #(
  parameter int PW = 7
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              enable,
  input  wire tmcp_pkg::tmcp_prescale_select_t prescale_select_sel,
  output logic                   tick
);
  import tmcp_pkg::*;

  logic [PW-1:0] div_ff;
  logic [PW-1:0] nxt_div;
  logic [PW-1:0] mask;

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_mask
      assign mask[gi] = (gi < int'(prescale_select_sel));
    end
  endgenerate

  // Tick when the low bits selected by the field are all ones
  assign tick = enable && (&(div_ff | ~mask));

  always_comb begin
    nxt_div = enable ? div_ff + 1'b1 : '0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  a_pre_cleared: assert property (@(posedge clk) disable iff (sys_rst)
    !enable |=> (div_ff == '0)) else $error("prescaler not cleared");

  a_pre_div_two: assert property (@(posedge clk) disable iff (sys_rst)
    (tick && prescale_select_sel == 3'h1) ##1 (enable && prescale_select_sel == 3'h1) |-> !tick)
    else $error("divide by two tick repeated");

  // Judged only while the setting survives; a disable may land in between
  a_pre_div_next: assert property (@(posedge clk) disable iff (sys_rst)
    (tick && prescale_select_sel == 3'h1) ##1 (enable && prescale_select_sel == 3'h1)
    ##1 (enable && prescale_select_sel == 3'h1) |-> tick) else $error("divide by two tick missing");
endmodule

//--- hw/tmcp_timer.sv
// Multimode 16-bit timer with capture and dual PWM, Avalon-MM register slave.
// Assumes timer_input is synchronous to clk; pin muxing lives outside.
`timescale 1ns/1ps
`include "tmcp_regs.svh"
module tmcp_timer #(
  parameter int CW = 16,
  parameter int DW = 3
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        timer_input,
  output logic             timer_output_pin,
  output logic             timer_output_pin_oe,
  output logic             timer_output_comp,
  output logic             timer_output_comp_oe,
  output logic             cpu_irq
);
  import tmcp_pkg::*;

  logic            ack_ff;
  logic [31:0]     rdata_ff;
  logic            nxt_ack;
  logic [31:0]     nxt_rdata;

  logic            en_ff;
  logic            pol_ff;
  tmcp_prescale_select_t      prescale_select_ff;
  tmcp_mode_t      mode_ff;
  logic [1:0]      icfg_ff;
  logic [DW-1:0]   dly_ff;
  logic            gie_ff;
  logic            oae_ff;
  logic [CW-1:0]   cnt_ff;
  logic [CW-1:0]   rld_ff;
  logic [CW-1:0]   pwm_ff;
  logic            flag_ff;
  logic            req_ff;
  logic            phase_ff;
  logic [DW-1:0]   dcnt_ff;
  logic            out_ff;
  logic            comp_ff;
  tmcp_run_e       st_ff;

  logic            nxt_en;
  logic            nxt_pol;
  tmcp_prescale_select_t      nxt_prescale_select;
  tmcp_mode_t      nxt_mode;
  logic [1:0]      nxt_icfg;
  logic [DW-1:0]   nxt_dly;
  logic            nxt_gie;
  logic            nxt_oae;
  logic [CW-1:0]   nxt_cnt;
  logic [CW-1:0]   nxt_rld;
  logic [CW-1:0]   nxt_pwm;
  logic            nxt_flag;
  logic            nxt_req;
  logic            nxt_phase;
  logic [DW-1:0]   nxt_dcnt;
  logic            nxt_out;
  logic            nxt_comp;
  tmcp_run_e       nxt_st;

  logic            req_any;
  logic            wr_go;
  logic            mapped;
  logic [2:0]      sel;
  logic [31:0]     cur_word;
  logic [31:0]     wword;
  logic            in_rise;
  logic            in_fall;
  logic            edge_sel;
  logic            pre_tick;
  logic            tick;
  logic            run;
  logic            is_edge_mode;
  logic            is_cap_mode;
  logic            cap_hit;
  logic            rld_hit;
  logic            match_hit;
  logic            irq_evt;
  logic            wr_cnt;

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_w & ~m) | (new_w & m);
  endfunction

  tmcp_prescaler #(.PW(7)) u_pre (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .enable   (en_ff),
    .prescale_select_sel (prescale_select_ff),
    .tick     (pre_tick)
  );

  tmcp_edge u_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig     (timer_input),
    .rise    (in_rise),
    .fall    (in_fall)
  );

  // Bus side: every access waits exactly one cycle
  assign req_any         = avs_read || avs_write;
  assign avs_waitrequest = req_any && !ack_ff;
  assign avs_readdata    = rdata_ff;
  assign wr_go           = avs_write && ack_ff;
  assign sel             = avs_address[4:2];
  assign mapped          = (avs_address[1:0] == 2'h0) && (sel <= `TMCP_OFS_PINCFG);
  assign wr_cnt          = wr_go && mapped && (sel == `TMCP_OFS_COUNT);

  always_comb begin
    cur_word = '0;
    unique case (sel)
      `TMCP_OFS_CTL1: begin
        cur_word[`TMCP_C1_MODE_LO] = mode_ff[2:0];
        cur_word[`TMCP_C1_PRESCALE_SELECT]    = prescale_select_ff;
        cur_word[`TMCP_C1_POL]     = pol_ff;
        cur_word[`TMCP_C1_EN]      = en_ff;
        cur_word[`TMCP_C1_ICFG]    = icfg_ff;
        cur_word[`TMCP_C1_FLAG]    = flag_ff;
      end
      `TMCP_OFS_CTL0: begin
        cur_word[`TMCP_C0_MODE_HI] = mode_ff[3];
        cur_word[`TMCP_C0_DLY]     = dly_ff;
      end
      `TMCP_OFS_COUNT:  cur_word = {{(32-CW){1'b0}}, cnt_ff};
      `TMCP_OFS_RELOAD: cur_word = {{(32-CW){1'b0}}, rld_ff};
      `TMCP_OFS_PWM:    cur_word = {{(32-CW){1'b0}}, pwm_ff};
      `TMCP_OFS_INTERRUPT_REQUEST_TWO:   cur_word[`TMCP_INTERRUPT_REQUEST_TWO_TMR] = req_ff;
      `TMCP_OFS_PINCFG: begin
        cur_word[`TMCP_PIN_GIE] = gie_ff;
        cur_word[`TMCP_PIN_OAE] = oae_ff;
      end
      default: cur_word = '0;
    endcase
    if (!mapped) begin
      cur_word = '0;
    end
    wword = merge(cur_word, avs_writedata, avs_byteenable);
  end

  always_comb begin
    nxt_ack   = req_any && !ack_ff;
    nxt_rdata = (avs_read && !ack_ff) ? cur_word : rdata_ff;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Timer datapath
  assign edge_sel     = pol_ff ? in_fall : in_rise;
  assign is_edge_mode = (mode_ff == `TMCP_MODE_COUNTER) || (mode_ff == `TMCP_MODE_CMPCNT);
  assign is_cap_mode  = (mode_ff == `TMCP_MODE_CAPTURE) || (mode_ff == `TMCP_MODE_CAPRST)
                        || (mode_ff == `TMCP_MODE_CAPCMP);
  assign tick         = is_edge_mode ? edge_sel : pre_tick;
  assign run          = en_ff && (st_ff == TMCP_RUN);
  assign cap_hit      = run && is_cap_mode && edge_sel;
  assign rld_hit      = run && tick && (cnt_ff == rld_ff);
  assign match_hit    = run && tick && (cnt_ff == pwm_ff) && (mode_ff == `TMCP_MODE_DUAL);
  assign irq_evt      = (cap_hit && icfg_ff != `TMCP_ICFG_RLD)
                        || (rld_hit && icfg_ff != `TMCP_ICFG_CAP);
  assign cpu_irq      = req_ff && gie_ff;
  assign timer_output_pin     = out_ff;
  assign timer_output_comp    = comp_ff;
  assign timer_output_pin_oe  = oae_ff;
  assign timer_output_comp_oe = oae_ff;

  always_comb begin
    nxt_en    = en_ff;
    nxt_pol   = pol_ff;
    nxt_prescale_select  = prescale_select_ff;
    nxt_mode  = mode_ff;
    nxt_icfg  = icfg_ff;
    nxt_dly   = dly_ff;
    nxt_gie   = gie_ff;
    nxt_oae   = oae_ff;
    nxt_cnt   = cnt_ff;
    nxt_rld   = rld_ff;
    nxt_pwm   = pwm_ff;
    nxt_flag  = flag_ff;
    nxt_req   = req_ff;
    nxt_phase = phase_ff;
    nxt_dcnt  = dcnt_ff;
    nxt_out   = out_ff;
    nxt_comp  = comp_ff;
    nxt_st    = st_ff;

    // Capture/compare waits for its first qualifying edge
    unique case (st_ff)
      TMCP_IDLE:  if (en_ff) begin
        nxt_st = (mode_ff == `TMCP_MODE_CAPCMP) ? TMCP_ARMED : TMCP_RUN;
      end
      TMCP_ARMED: if (edge_sel) begin
        nxt_st = TMCP_RUN;
      end
      TMCP_RUN:   nxt_st = TMCP_RUN;
    endcase
    if (!en_ff) begin
      nxt_st = TMCP_IDLE;
    end

    // Reload lands on 0001H unless a count write wins that cycle; start value only counts once
    if (rld_hit) begin
      nxt_cnt = `TMCP_RELOAD_CNT;
    end else if (cap_hit && mode_ff == `TMCP_MODE_CAPRST) begin
      nxt_cnt = `TMCP_RELOAD_CNT;
    end else if (run && tick) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    if (cap_hit) begin
      nxt_pwm = cnt_ff;
    end

    if (rld_hit && is_cap_mode) begin
      nxt_flag = 1'b0;
    end
    if (cap_hit) begin
      nxt_flag = 1'b1;
    end

    // Pins: idle level is the polarity bit (inverted on comp), sampled only while disabled except in dual mode
    if (!en_ff) begin
      nxt_phase = 1'b0;
      nxt_dcnt  = '0;
      nxt_out   = pol_ff;
      nxt_comp  = !pol_ff;
    end else if (mode_ff == `TMCP_MODE_DUAL) begin
      if (rld_hit) begin
        nxt_phase = 1'b0;
        nxt_dcnt  = dly_ff;
      end else if (match_hit) begin
        nxt_phase = 1'b1;
        nxt_dcnt  = dly_ff;
      end else if (dcnt_ff != '0) begin
        nxt_dcnt = dcnt_ff - 1'b1;
      end
      // Both sides stay deasserted during the dead band
      nxt_out  = pol_ff ^ (nxt_phase && nxt_dcnt == '0);
      nxt_comp = pol_ff ^ !(nxt_phase || nxt_dcnt != '0);
    end else if (rld_hit) begin
      nxt_out  = !out_ff;
      nxt_comp = out_ff;
    end

    // Bus writes; software must reconfigure only while disabled
    if (wr_go && mapped) begin
      unique case (sel)
        `TMCP_OFS_CTL1: begin
          nxt_mode[2:0] = wword[`TMCP_C1_MODE_LO];
          nxt_prescale_select      = wword[`TMCP_C1_PRESCALE_SELECT];
          nxt_pol       = wword[`TMCP_C1_POL];
          nxt_en        = wword[`TMCP_C1_EN];
          nxt_icfg      = wword[`TMCP_C1_ICFG];
        end
        `TMCP_OFS_CTL0: begin
          nxt_mode[3] = wword[`TMCP_C0_MODE_HI];
          nxt_dly     = wword[`TMCP_C0_DLY];
        end
        `TMCP_OFS_COUNT:  nxt_cnt = wword[CW-1:0];
        `TMCP_OFS_RELOAD: nxt_rld = wword[CW-1:0];
        `TMCP_OFS_PWM:    nxt_pwm = wword[CW-1:0];
        `TMCP_OFS_INTERRUPT_REQUEST_TWO:   if (wword[`TMCP_INTERRUPT_REQUEST_TWO_TMR] && avs_byteenable[0]) begin
          nxt_req = 1'b0;
        end
        `TMCP_OFS_PINCFG: begin
          nxt_gie = wword[`TMCP_PIN_GIE];
          nxt_oae = wword[`TMCP_PIN_OAE];
        end
        default: nxt_req = nxt_req;
      endcase
    end
    // A new event beats a clear in the same cycle
    if (irq_evt) begin
      nxt_req = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_ff    <= 1'b0;
      pol_ff   <= 1'b0;
      prescale_select_ff  <= '0;
      mode_ff  <= `TMCP_RST_MODE;
      icfg_ff  <= `TMCP_ICFG_BOTH;
      dly_ff   <= '0;
      gie_ff   <= 1'b0;
      oae_ff   <= 1'b0;
      cnt_ff   <= `TMCP_RST_COUNT;
      rld_ff   <= `TMCP_RST_RELOAD;
      pwm_ff   <= `TMCP_RST_PWM;
      flag_ff  <= 1'b0;
      req_ff   <= 1'b0;
      phase_ff <= 1'b0;
      dcnt_ff  <= '0;
      out_ff   <= 1'b0;
      comp_ff  <= 1'b1;
      st_ff    <= TMCP_IDLE;
    end else begin
      en_ff    <= nxt_en;
      pol_ff   <= nxt_pol;
      prescale_select_ff  <= nxt_prescale_select;
      mode_ff  <= nxt_mode;
      icfg_ff  <= nxt_icfg;
      dly_ff   <= nxt_dly;
      gie_ff   <= nxt_gie;
      oae_ff   <= nxt_oae;
      cnt_ff   <= nxt_cnt;
      rld_ff   <= nxt_rld;
      pwm_ff   <= nxt_pwm;
      flag_ff  <= nxt_flag;
      req_ff   <= nxt_req;
      phase_ff <= nxt_phase;
      dcnt_ff  <= nxt_dcnt;
      out_ff   <= nxt_out;
      comp_ff  <= nxt_comp;
      st_ff    <= nxt_st;
    end
  end

  a_cnt_reload_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_ff == `TMCP_MODE_COUNTER) && run && edge_sel && cnt_ff == rld_ff && !wr_cnt
    |=> cnt_ff == 16'h0001 && req_ff) else $error("counter reload wrong");

  a_cnt_no_prescale: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_ff == `TMCP_MODE_COUNTER) && run && !edge_sel && !wr_cnt
    |=> $stable(cnt_ff)) else $error("counter moved without edge");

  a_cap_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    cap_hit |=> flag_ff && pwm_ff == $past(cnt_ff)) else $error("capture missed");

  a_cap_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rld_hit && is_cap_mode && !cap_hit |=> !flag_ff) else $error("flag not cleared");

  a_irq_req_set: assert property (@(posedge clk) disable iff (sys_rst)
    irq_evt |=> req_ff && (cpu_irq == gie_ff)) else $error("request lost");

  a_icfg_cap_only: assert property (@(posedge clk) disable iff (sys_rst)
    icfg_ff == `TMCP_ICFG_CAP && rld_hit && !cap_hit && !req_ff |=> !req_ff)
    else $error("reload irq not masked");

  a_dual_idle_lvl: assert property (@(posedge clk) disable iff (sys_rst)
    !en_ff ##1 !en_ff |-> out_ff == $past(pol_ff) && comp_ff == !$past(pol_ff))
    else $error("idle levels wrong");

  a_dual_dead_band: assert property (@(posedge clk) disable iff (sys_rst)
    en_ff && mode_ff == `TMCP_MODE_DUAL && match_hit && !rld_hit && dly_ff != '0
    |=> out_ff == pol_ff && comp_ff == pol_ff) else $error("dead band missing");

  a_ccmp_armed_hold: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff == TMCP_ARMED && !wr_cnt |=> $stable(cnt_ff)) else $error("counted before edge");
endmodule

//--- inc/tmcp_pkg.sv
// Types shared by the timer modules.
// Assumes tmcp_regs.svh supplies the numeric constants.
package tmcp_pkg;
  typedef logic [3:0] tmcp_mode_t;
  typedef logic [2:0] tmcp_prescale_select_t;
  typedef enum logic [2:0] {
    TMCP_IDLE  = 3'b001,
    TMCP_ARMED = 3'b010,
    TMCP_RUN   = 3'b100
  } tmcp_run_e;
endpackage

//--- inc/tmcp_regs.svh
// Offsets, field positions, reset values and mode codes of the timer.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
// Contract
// - Counter mode counts input edges chosen by polarity
// - Counter mode bypasses the prescaler
// - Counter reload interrupts, reloads 0001H, continues
// - Counter reload toggles enabled output pin
// - Written start count only for first pass
// - Capture sets flag, interrupts, keeps counting
// - Capture mode reload interrupts, clears flag
// - Source config limits interrupt to capture/reload
// - Capture restart copies count on chosen edge
// - Capture/compare starts on first edge, captures after
// - Dual PWM polarity 0 levels and transitions
// - Dual PWM polarity 1 inverts all levels
// - Delay cycles before outputs reach asserted level
// - Comparator counter idles at polarity, toggles reload
// - Output shows polarity when disabled, not instantly
// - Prescaler divides by two to the field
// - Prescaler clears whenever timer is disabled
// - Four-bit mode code, top bit separate
// - Request bit sets; forwarded only if enabled
`ifndef TMCP_REGS_SVH
`define TMCP_REGS_SVH

`define TMCP_OFS_CTL1    3'h0
`define TMCP_OFS_CTL0    3'h1
`define TMCP_OFS_COUNT   3'h2
`define TMCP_OFS_RELOAD  3'h3
`define TMCP_OFS_PWM     3'h4
`define TMCP_OFS_INTERRUPT_REQUEST_TWO    3'h5
`define TMCP_OFS_PINCFG  3'h6

`define TMCP_C1_MODE_LO  2:0
`define TMCP_C1_PRESCALE_SELECT     5:3
`define TMCP_C1_POL      6
`define TMCP_C1_EN       7
`define TMCP_C1_ICFG     9:8
`define TMCP_C1_FLAG     10
`define TMCP_C0_MODE_HI  0
`define TMCP_C0_DLY      3:1
`define TMCP_INTERRUPT_REQUEST_TWO_TMR    0
`define TMCP_PIN_GIE     0
`define TMCP_PIN_OAE     1

`define TMCP_RST_COUNT   16'h0001
`define TMCP_RST_RELOAD  16'hffff
`define TMCP_RST_PWM     16'h0000
`define TMCP_RST_MODE    4'h0
`define TMCP_RELOAD_CNT  16'h0001

`define TMCP_ICFG_BOTH   2'h0
`define TMCP_ICFG_CAP    2'h1
`define TMCP_ICFG_RLD    2'h2

`define TMCP_MODE_ONESHOT  4'h0
`define TMCP_MODE_CONT     4'h1
`define TMCP_MODE_COUNTER  4'h2
`define TMCP_MODE_PWM1     4'h3
`define TMCP_MODE_CAPTURE  4'h4
`define TMCP_MODE_COMPARE  4'h5
`define TMCP_MODE_GATED    4'h6
`define TMCP_MODE_CAPCMP   4'h7
`define TMCP_MODE_DUAL     4'h8
`define TMCP_MODE_CAPRST   4'h9
`define TMCP_MODE_CMPCNT   4'ha

`endif

//--- tb/tb.sv
// Self-checking bench for the multimode timer over its register bus and pins.
// Assumes the pin model as far side and a 25 MHz clock.
`timescale 1ns/1ps
`include "tmcp_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, (e), (g)); end end
module tb;
  logic        clk, sys_rst, avs_read, avs_write, go, slow, cpu_irq, busy;
  logic        pin, pin_oe, comp, comp_oe, waitreq, tin, lvl;
  logic        wr_s, busy_s, pin_s, comp_s, oe_s, coe_s, irq_s, lvl_s;
  logic [4:0]  avs_address;
  logic [7:0]  n_tog;
  logic [31:0] avs_writedata, avs_readdata, rd_s, cur_c1, d, c;
  int          fails, n_compared, cyc;

  tmcp_timer dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(waitreq),
    .timer_input(tin), .timer_output_pin(pin), .timer_output_pin_oe(pin_oe),
    .timer_output_comp(comp), .timer_output_comp_oe(comp_oe), .cpu_irq(cpu_irq));
  tmcp_pin_model far_u (.clk(clk), .sys_rst(sys_rst), .go(go), .slow(slow),
    .n_toggle(n_tog), .pin_out(pin), .pin_oe(pin_oe), .timer_input(tin),
    .busy(busy), .pin_level(lvl));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Snapshots mid-cycle, so edge-time races never decide a check
  always @(negedge clk) begin
    wr_s   = waitreq;
    rd_s   = avs_readdata;
    busy_s = busy;
    pin_s  = pin;
    comp_s = comp;
    oe_s   = pin_oe;
    coe_s  = comp_oe;
    irq_s  = cpu_irq;
    lvl_s  = lvl;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] o, input logic [31:0] wd);
    avs_address   <= {o, 2'b00};
    avs_read      <= ~w;
    avs_write     <= w;
    avs_writedata <= wd;
    do @(posedge clk); while (wr_s !== 1'b0);
    d = rd_s;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cfg(input logic [3:0] m, input logic [2:0] p, input logic pol,
      input logic [1:0] ic, input logic [2:0] dl, input logic [15:0] cn,
      input logic [15:0] rl, input logic [15:0] pw);
    cur_c1 = {22'h0, ic, 1'b0, pol, p, m[2:0]};
    bus(1, `TMCP_OFS_CTL1, cur_c1);
    bus(1, `TMCP_OFS_CTL0, {28'h0, dl, m[3]});
    bus(1, `TMCP_OFS_COUNT, {16'h0, cn});
    bus(1, `TMCP_OFS_RELOAD, {16'h0, rl});
    bus(1, `TMCP_OFS_PWM, {16'h0, pw});
    bus(1, `TMCP_OFS_INTERRUPT_REQUEST_TWO, 32'h1);
    bus(1, `TMCP_OFS_PINCFG, 32'h3);
    repeat (2) @(posedge clk);
  endtask
  task automatic en();
    cur_c1[`TMCP_C1_EN] = 1'b1;
    bus(1, `TMCP_OFS_CTL1, cur_c1);
  endtask
  task automatic tog(input logic [7:0] n);
    go    <= 1'b1;
    n_tog <= n;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy_s);
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [3:0] m;
    `CHK("rst_pin", 1'b0, pin_s)
    `CHK("rst_comp", 1'b1, comp_s)
    `CHK("rst_oe", 2'b00, {oe_s, coe_s})
    `CHK("rst_irq", 1'b0, irq_s)
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    `CHK("rst_count", {16'h0, `TMCP_RST_COUNT}, d)
    bus(0, `TMCP_OFS_RELOAD, 32'h0);
    `CHK("rst_reload", {16'h0, `TMCP_RST_RELOAD}, d)
    bus(1, 3'h7, 32'hffff_ffff);
    bus(0, 3'h7, 32'h0);
    `CHK("unmapped", 32'h0, d)
    for (int i = 0; i <= 10; i++) begin
      m = 4'(i);
      bus(1, `TMCP_OFS_CTL1, {29'h0, m[2:0]});
      bus(1, `TMCP_OFS_CTL0, {31'h0, m[3]});
      bus(0, `TMCP_OFS_CTL1, 32'h0);
      c = d;
      bus(0, `TMCP_OFS_CTL0, 32'h0);
      `CHK("mode_code", m, {d[0], c[2:0]})
    end
  endtask
  task automatic t_counter(input logic pol);
    cfg(`TMCP_MODE_COUNTER, 3'h7, pol, 2'h0, 3'h0, 16'h1, 16'h3, 16'h0);
    `CHK("cnt_idle_pin", pol, lvl_s)
    `CHK("cnt_oe", 2'b11, {oe_s, coe_s})
    en();
    tog(8'h4);
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    `CHK("cnt_edges", 32'h3, d)
    tog(8'h1);
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    `CHK("cnt_polarity", pol ? 32'h3 : 32'h1, d)
    tog(8'h1);
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    `CHK("cnt_reload", {16'h0, `TMCP_RELOAD_CNT}, d)
    `CHK("cnt_pin", ~pol, lvl_s)
    `CHK("cnt_irq", 1'b1, irq_s)
    bus(1, `TMCP_OFS_PINCFG, 32'h2);
    `CHK("cnt_masked", 1'b0, irq_s)
    bus(0, `TMCP_OFS_INTERRUPT_REQUEST_TWO, 32'h0);
    `CHK("cnt_polled", 32'h1, d)
  endtask
  task automatic t_prescale();
    for (int p = 0; p < 8; p++) begin
      cfg(`TMCP_MODE_CAPTURE, 3'(p), 1'b0, 2'h0, 3'h0, 16'h1, 16'hffff, 16'h0);
      en();
      bus(0, `TMCP_OFS_COUNT, 32'h0);
      c = d;
      repeat (253) @(posedge clk);
      bus(0, `TMCP_OFS_COUNT, 32'h0);
      `CHK("prescale", 32'h100 >> p, d - c)
    end
  endtask
  task automatic t_capture(input logic [1:0] ic);
    cfg(`TMCP_MODE_CAPTURE, 3'h0, 1'b0, ic, 3'h0, 16'h1, 16'h100, 16'h0);
    en();
    repeat (20) @(posedge clk);
    tog(8'h2);
    bus(0, `TMCP_OFS_CTL1, 32'h0);
    `CHK("cap_flag", 1'b1, d[`TMCP_C1_FLAG])
    bus(0, `TMCP_OFS_PWM, 32'h0);
    c = d;
    `CHK("cap_value", 1'b1, c != 32'h0)
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    `CHK("cap_runs", 1'b1, d > c)
    bus(0, `TMCP_OFS_INTERRUPT_REQUEST_TWO, 32'h0);
    `CHK("cap_irq", ic != `TMCP_ICFG_RLD, d[0])
    bus(1, `TMCP_OFS_INTERRUPT_REQUEST_TWO, 32'h1);
    repeat (300) @(posedge clk);
    bus(0, `TMCP_OFS_CTL1, 32'h0);
    `CHK("rld_flag", 1'b0, d[`TMCP_C1_FLAG])
    bus(0, `TMCP_OFS_INTERRUPT_REQUEST_TWO, 32'h0);
    `CHK("rld_irq", ic != `TMCP_ICFG_CAP, d[0])
  endtask
  task automatic t_caprst();
    cfg(`TMCP_MODE_CAPRST, 3'h0, 1'b1, 2'h0, 3'h0, 16'h1, 16'hffff, 16'h0);
    en();
    repeat (40) @(posedge clk);
    tog(8'h1);
    bus(0, `TMCP_OFS_PWM, 32'h0);
    `CHK("crs_rise", 32'h0, d)
    tog(8'h1);
    bus(0, `TMCP_OFS_PWM, 32'h0);
    c = d;
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    `CHK("crs_restart", 1'b1, d < c && c > 32'h1)
  endtask
  task automatic t_capcmp();
    slow <= 1'b1;
    cfg(`TMCP_MODE_CAPCMP, 3'h0, 1'b0, 2'h0, 3'h0, 16'h1, 16'hffff, 16'h0);
    en();
    repeat (30) @(posedge clk);
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    `CHK("cc_armed", 32'h1, d)
    tog(8'h1);
    bus(0, `TMCP_OFS_COUNT, 32'h0);
    c = d;
    `CHK("cc_started", 1'b1, c > 32'h1)
    tog(8'h2);
    bus(0, `TMCP_OFS_PWM, 32'h0);
    `CHK("cc_capture", 1'b1, d > c)
    slow <= 1'b0;
  endtask
  task automatic t_dual(input logic pol, input logic [2:0] dl);
    int n_hi = 0;
    int n_dead = 0;
    cfg(`TMCP_MODE_DUAL, 3'h0, pol, 2'h0, dl, 16'h1, 16'h8, 16'h4);
    `CHK("dual_off_pin", pol, pin_s)
    `CHK("dual_off_comp", ~pol, comp_s)
    en();
    repeat (64) begin
      @(posedge clk);
      n_hi += int'(pin_s);
      n_dead += int'(pin_s === pol && comp_s === pol);
    end
    `CHK("dual_duty", pol ? 64 - 8 * (4 - int'(dl)) : 8 * (4 - int'(dl)), n_hi)
    `CHK("dual_delay", dl != 3'h0, n_dead > 0)
  endtask
  task automatic t_cmpcnt();
    cfg(`TMCP_MODE_CMPCNT, 3'h0, 1'b1, 2'h0, 3'h0, 16'h1, 16'h2, 16'h0);
    `CHK("cmp_idle", 1'b1, lvl_s)
    en();
    cur_c1[`TMCP_C1_POL] = 1'b0;
    bus(1, `TMCP_OFS_CTL1, cur_c1);
    `CHK("cmp_polchg", 1'b1, lvl_s)
    tog(8'h4);
    `CHK("cmp_toggle", 1'b0, lvl_s)
  endtask

  initial begin
    sys_rst       = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 5'h0;
    avs_writedata = 32'h0;
    go            = 1'b0;
    slow          = 1'b0;
    n_tog         = 8'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_counter(1'b0);
    t_counter(1'b1);
    t_prescale();
    t_capture(`TMCP_ICFG_BOTH);
    t_capture(`TMCP_ICFG_CAP);
    t_capture(`TMCP_ICFG_RLD);
    t_caprst();
    t_capcmp();
    t_dual(1'b0, 3'h0);
    t_dual(1'b1, 3'h0);
    t_dual(1'b0, 3'h3);
    t_dual(1'b1, 3'h3);
    t_cmpcnt();
    test_done();
  end
endmodule

//--- tb/tmcp_pin_model.sv
// Far-side model: drives the timer input pin and resolves the output pin.
// Assumes the bench asks for a burst of toggles with a one-cycle go strobe.
`timescale 1ns/1ps
module tmcp_pin_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [7:0] n_toggle,
  input  wire logic       pin_out,
  input  wire logic       pin_oe,
  output logic            timer_input,
  output logic            busy,
  output logic            pin_level
);
  logic [7:0] left_ff;
  logic [2:0] gap_ff;
  // Undriven pin falls to its pull-down
  assign pin_level = pin_oe ? pin_out : 1'b0;
  assign busy      = (left_ff != 8'h00);
  // Level held 4 or 8 cycles, inside the quarter-rate limit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      left_ff     <= 8'h00;
      gap_ff      <= 3'h0;
      timer_input <= 1'b0;
    end else if (go) begin
      left_ff <= n_toggle;
      gap_ff  <= 3'h0;
    end else if (busy) begin
      gap_ff <= gap_ff + 3'h1;
      if (gap_ff == {slow, 2'h3}) begin
        timer_input <= ~timer_input;
        left_ff     <= left_ff - 8'h01;
        gap_ff      <= 3'h0;
      end
    end
  end
endmodule
